// *** rtl/sleep_gate.sv ***
/*
  sleep sequencer and peripheral clock gating with apb registers.
  holds the core control and gating registers, the sleep state
  machine with its start-up and halt counts, the clock domain enables
  per sleep mode, the peripheral clock and access gates, and the
  analog enables for converter, comparator, reference, brown-out
  detector, watchdog and input buffers.
  assumes the core pulses sleep on a sleep instruction and that wake,
  crystal and fuse levels arrive from outside the clock domain.
  assumes an apb master that holds each request through its access
  phase; the slave answers every access phase at once, with no wait.
  assumes the chip gates its clocks from the registered enables here,
  so every enable lags its cause by one clock.
  assumes the peripherals keep their own state while their clock is
  held off; nothing here saves or restores that state.
*/
`timescale 1ns/1ps
`default_nettype none
module sleep_gate #(
  parameter int STARTUP_CYCLES = 16
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [31:0] O_PRDATA,
  // core interface
  input wire logic I_SLEEP_INSTR,
  output logic O_CORE_STALL,
  output logic O_SLEEP_NOP,
  // wake and configuration levels from pins
  input wire logic I_WAKE_IRQ,
  input wire logic I_CRYSTAL_SEL,
  input wire logic I_BOD_FUSE_EN,
  input wire logic I_WDT_EN,
  input wire logic I_ADC_EN,
  input wire logic I_COMP_EN,
  input wire logic I_COMP_USES_REF,
  // clock domain and peripheral gates
  output sleep_gate_pkg::clk_dom_t O_CLK_DOM,
  output logic [3:0] O_PERIPH_CLK_EN,
  output logic [3:0] O_PERIPH_ACCESS_EN,
  output sleep_gate_pkg::analog_t O_ANALOG
);

  // registers
  logic [7:0] core_control; // arm and mode
  logic [7:0] gating; // peripheral gates
  // synchronisers: stage one read by stage two only
  logic [6:0] sync1;
  logic [6:0] sync2;
  // sequencer
  sleep_gate_pkg::core_state_t state;
  sleep_gate_pkg::core_state_t next_state;
  logic [1:0] mode; // mode latched at sleep entry
  logic [1:0] next_mode;
  logic [sleep_gate_pkg::CNT_W-1:0] count;
  logic [sleep_gate_pkg::CNT_W-1:0] next_count;
  logic adc_prev; // adc on last cycle
  logic adc_ext; // next conversion extended

  // named synchronised levels
  wire wake = sync2[0];
  wire crystal = sync2[1];
  wire bod_fuse = sync2[2];
  wire wdt_en = sync2[3];
  wire adc_en = sync2[4];
  wire comp_en = sync2[5];
  wire comp_ref = sync2[6];

  // apb decode
  // setup is the first cycle of a transfer, access the answered one
  // writes land only at the access edge, with ready high, so a
  // request that the master drops early never changes a register
  // unmapped addresses raise the error flag and write nothing
  // reads of reserved bits come back as zero through the masks
  wire setup = I_PSEL & ~I_PENABLE;
  wire access = I_PSEL & I_PENABLE;
  wire hit_core = I_PADDR == sleep_gate_pkg::OFS_CORE_CONTROL;
  wire hit_gate = I_PADDR == sleep_gate_pkg::OFS_GATING;
  wire hit_stat = I_PADDR == sleep_gate_pkg::OFS_STATUS;
  wire mapped = hit_core | hit_gate | hit_stat;
  wire wr_core = access & O_PREADY & I_PWRITE & hit_core;
  wire wr_gate = access & O_PREADY & I_PWRITE & hit_gate;
  // masks keep reserved bits at zero
  wire [7:0] core_wdata = I_PWDATA[7:0] & sleep_gate_pkg::CORE_CONTROL_WMASK;
  wire [7:0] gate_wdata = I_PWDATA[7:0] & sleep_gate_pkg::GATING_WMASK;
  wire [7:0] status_word = {4'h0, crystal, 1'b0, state != sleep_gate_pkg::ST_RUN,
                            state == sleep_gate_pkg::ST_SLEEP};
  wire [7:0] rd_byte = hit_core ? core_control :
                       hit_gate ? gating :
                       hit_stat ? status_word : 8'h00;

  // sleep entry decision
  // the arm bit is sampled in the same cycle as the sleep pulse
  // an unarmed pulse only answers with the no-operation strobe
  // the mode is latched at entry, so later register writes made
  // while asleep cannot change the running sleep mode
  wire arm = core_control[sleep_gate_pkg::SLEEP_ARM_BIT];
  wire [1:0] req_mode = core_control[sleep_gate_pkg::MODE_HI:sleep_gate_pkg::MODE_LO];
  // standby without crystal falls back to power-down
  wire [1:0] entry_mode = (req_mode == sleep_gate_pkg::MODE_STANDBY && !crystal)
                          ? sleep_gate_pkg::MODE_POWER_DOWN : req_mode;
  wire take_sleep = (state == sleep_gate_pkg::ST_RUN) & I_SLEEP_INSTR & arm;
  wire nop_sleep = (state == sleep_gate_pkg::ST_RUN) & I_SLEEP_INSTR & ~arm;
  wire asleep = state == sleep_gate_pkg::ST_SLEEP;
  // wake start-up length depends on mode
  wire [sleep_gate_pkg::CNT_W-1:0] startup_len = (mode == sleep_gate_pkg::MODE_STANDBY)
      ? sleep_gate_pkg::CNT_W'(sleep_gate_pkg::STANDBY_WAKE_CYCLES)
      : sleep_gate_pkg::CNT_W'(STARTUP_CYCLES);

  // per-mode clock domains
  // idle keeps io and adc clocks, noise reduction only the adc clock
  // power-down stops all generated clocks and the oscillator
  // standby keeps the oscillator so that wake-up is short
  // the halt cycles after start-up count as running clocks
  wire in_sleep = asleep | (state == sleep_gate_pkg::ST_STARTUP);
  wire dom_io = !in_sleep || mode == sleep_gate_pkg::MODE_IDLE;
  wire dom_adc = !in_sleep || mode == sleep_gate_pkg::MODE_IDLE
                 || mode == sleep_gate_pkg::MODE_ADC_NR;
  wire dom_osc = dom_adc || mode == sleep_gate_pkg::MODE_STANDBY;
  wire deep = in_sleep && (mode == sleep_gate_pkg::MODE_POWER_DOWN
              || mode == sleep_gate_pkg::MODE_STANDBY);
  // peripheral clock gating only matters where io clock runs; the converter bit also gates adc clock and power
  wire [3:0] periph_run = ~gating[3:0] & {4{dom_io}};
  wire adc_clock = dom_adc & ~gating[sleep_gate_pkg::GATE_CONVERTER];
  wire adc_on_now = adc_en & ~gating[sleep_gate_pkg::GATE_CONVERTER];
  wire comp_on_now = comp_en & ~deep;
  wire ref_need = bod_fuse | (comp_en & comp_ref) | adc_on_now;

  // next-state logic for the sleep sequencer
  // run waits for an armed pulse, sleep waits for a synced wake,
  // start-up counts down its length, halt counts four more cycles
  // counters load length minus one so that zero ends the phase
  // sleep pulses outside run are ignored on purpose
  always_comb
  begin
    next_state = state;
    next_mode = mode;
    next_count = count;
    unique case (state)
      sleep_gate_pkg::ST_RUN:
      begin
        // armed sleep latches the mode
        if (take_sleep)
        begin
          next_state = sleep_gate_pkg::ST_SLEEP;
          next_mode = entry_mode;
        end
      end
      sleep_gate_pkg::ST_SLEEP:
      begin
        // wake starts the start-up count
        if (wake)
        begin
          next_state = sleep_gate_pkg::ST_STARTUP;
          next_count = startup_len - 1'b1;
        end
      end
      sleep_gate_pkg::ST_STARTUP:
      begin
        // start-up done, then fixed halt
        if (count == '0)
        begin
          next_state = sleep_gate_pkg::ST_HALT;
          next_count = sleep_gate_pkg::CNT_W'(sleep_gate_pkg::WAKE_HALT_CYCLES - 1);
        end
        else
          next_count = count - 1'b1;
      end
      sleep_gate_pkg::ST_HALT:
      begin
        // halt over, core resumes
        if (count == '0)
          next_state = sleep_gate_pkg::ST_RUN;
        else
          next_count = count - 1'b1;
      end
    endcase
  end

  // two-flop synchronisers for pin levels
  // every level here may change at any time relative to the clock
  // only the second stage feeds logic, so metastability settles
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {I_COMP_USES_REF, I_COMP_EN, I_ADC_EN, I_WDT_EN,
                I_BOD_FUSE_EN, I_CRYSTAL_SEL, I_WAKE_IRQ};
      sync2 <= sync1;
    end
  end

  // register writes, taken at the access edge while ready is high
  // the effect shows on the gates one clock after that edge
  // gating bits stop a peripheral but never reset it, so clearing
  // a bit lets the peripheral go on from where it stopped
  // software must idle a peripheral first; nothing here checks it
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      core_control <= sleep_gate_pkg::CORE_CONTROL_RESET;
      gating <= sleep_gate_pkg::GATING_RESET;
    end
    else
    begin
      // control register, reserved bits dropped
      if (wr_core)
        core_control <= core_wdata;
      // gating bits: timers, serial unit, adc
      if (wr_gate)
        gating <= gate_wdata;
    end
  end

  // apb answer: one-cycle access phase
  // ready, error and read data are flops loaded in the setup cycle,
  // so each stands for exactly the one access cycle
  // read data return to zero after the access to ease bus muxing
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= '0;
    end
    else
    begin
      O_PREADY <= setup;
      O_PSLVERR <= setup & ~mapped;
      // read data placed for the access edge
      if (setup & ~I_PWRITE)
        O_PRDATA <= {24'h0, rd_byte};
      else if (access)
        O_PRDATA <= '0;
    end
  end

  // sequencer registers
  // reset leaves the core running in idle mode with no count
  // a reset during sleep returns straight to run
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      state <= sleep_gate_pkg::ST_RUN;
      mode <= sleep_gate_pkg::MODE_IDLE;
      count <= '0;
    end
    else
    begin
      state <= next_state;
      mode <= next_mode;
      count <= next_count;
    end
  end

  // extended conversion after the adc was off
  // the flag starts set because the converter is cold after reset
  // being off wins over a clear in the same cycle
  // it clears once the converter has run for a clock with power on
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      adc_prev <= 1'b0;
      adc_ext <= 1'b1;
    end
    else
    begin
      adc_prev <= adc_on_now;
      // off sets the flag; a clock with adc on clears it
      if (!adc_on_now)
        adc_ext <= 1'b1;
      else if (adc_prev && adc_clock)
        adc_ext <= 1'b0;
    end
  end

  // registered outputs toward core, clocks and analog
  // stall follows the next state, so it rises with the entry edge
  // clock domain enables follow the present state, one clock later
  // access enables follow the gating bits in every mode
  // peripheral clocks also need the io clock to be running
  // brown-out, watchdog and reference ignore the sleep mode
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_CORE_STALL <= 1'b0;
      O_SLEEP_NOP <= 1'b0;
      O_CLK_DOM <= '1;
      O_PERIPH_CLK_EN <= '1;
      O_PERIPH_ACCESS_EN <= '1;
      O_ANALOG <= '0;
    end
    else
    begin
      O_CORE_STALL <= next_state != sleep_gate_pkg::ST_RUN;
      O_SLEEP_NOP <= nop_sleep;
      O_CLK_DOM.cpu <= !in_sleep;
      O_CLK_DOM.flash <= !in_sleep;
      O_CLK_DOM.io <= dom_io;
      O_CLK_DOM.adc <= adc_clock;
      O_CLK_DOM.osc <= dom_osc;
      O_PERIPH_CLK_EN <= periph_run;
      O_PERIPH_ACCESS_EN <= ~gating[3:0];
      O_ANALOG.adc_on <= adc_on_now;
      O_ANALOG.adc_extended <= adc_ext;
      O_ANALOG.comp_on <= comp_on_now;
      O_ANALOG.comp_adc_mux <= ~gating[sleep_gate_pkg::GATE_CONVERTER];
      O_ANALOG.bod_on <= bod_fuse;
      O_ANALOG.ref_on <= ref_need;
      O_ANALOG.wdt_run <= wdt_en;
      O_ANALOG.in_buf_on <= dom_io | dom_adc;
    end
  end

endmodule : sleep_gate
`default_nettype wire

// *** inc/sleep_gate_pkg.sv ***
/*
  constants, field layouts and types for the sleep and peripheral clock
  gating block. assumes a 32-bit apb slave and a 100 MHz system clock.
*/
// Contract
// - gated peripheral: clock stopped, state frozen, access blocked
// - ungating resumes peripheral in its prior state
// - gating acts only in active and idle; the converter bit also turns the adc off in every sleep mode
// - adc stays on in sleep; re-enable gives extended conversion
// - comparator off in deep sleep; reference kept if used
// - fuse-enabled brown-out detector stays on always
// - reference on only when bod, comparator or adc need
// - enabled watchdog keeps running in every sleep mode
// - input buffers off when io and adc clocks stop; code keeps them on in adc noise reduction with the converter gated
// - sleep taken only when arm bit five set
// - mode field bits four-three select idle/adc/down/standby
// - control register bit two reads zero
// - gating bits seven-four read zero; reset zero
// - gating bit three stops wide timer, resumes after
// - gating bit two stops narrow timer, resumes after
// - gating bit one stops serial unit clock
// - gating bit zero stops adc; comparator loses adc mux
// - interrupt wake: four-cycle halt plus start-up, then resume
// - standby needs crystal option; wakes in six cycles
package sleep_gate_pkg;
  // register byte offsets on apb
  localparam logic [7:0] OFS_CORE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_GATING = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // core control register fields
  localparam int SLEEP_ARM_BIT = 5;
  localparam int MODE_HI = 4;
  localparam int MODE_LO = 3;
  localparam logic [7:0] CORE_CONTROL_WMASK = 8'hF8;
  localparam logic [7:0] CORE_CONTROL_RESET = 8'h00;
  // gating register fields
  localparam int GATE_TIMER_WIDE = 3;
  localparam int GATE_TIMER_NARROW = 2;
  localparam int GATE_SERIAL_UNIT = 1;
  localparam int GATE_CONVERTER = 0;
  localparam logic [7:0] GATING_WMASK = 8'h0F;
  localparam logic [7:0] GATING_RESET = 8'h00;
  // sleep mode codes
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_ADC_NR = 2'h1;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
  localparam logic [1:0] MODE_STANDBY = 2'h3;
  // wake timing in clock cycles
  localparam int WAKE_HALT_CYCLES = 4;
  localparam int STANDBY_WAKE_CYCLES = 6;
  localparam int CNT_W = 8;
  // core sequencing states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STARTUP,
    ST_HALT
  } core_state_t;
  // clock domain enables handed to the chip
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic osc;
  } clk_dom_t;
  // analog enables
  typedef struct packed {
    logic adc_on;
    logic adc_extended;
    logic comp_on;
    logic comp_adc_mux;
    logic bod_on;
    logic ref_on;
    logic wdt_run;
    logic in_buf_on;
  } analog_t;
endpackage : sleep_gate_pkg

// *** dv/sleep_gate_sva.sv ***
/*
  assertion checker for the sleep and peripheral gating block.
  assumes it is bound to sleep_gate and sees that module's ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module sleep_gate_sva (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  // register bus
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic O_PREADY,
  input wire logic [31:0] O_PRDATA,
  // core handshake
  input wire logic I_SLEEP_INSTR,
  input wire logic O_CORE_STALL,
  input wire logic O_SLEEP_NOP,
  input wire logic I_WAKE_IRQ,
  // levels and gates
  input wire logic I_BOD_FUSE_EN,
  input wire logic I_WDT_EN,
  input wire sleep_gate_pkg::clk_dom_t O_CLK_DOM,
  input wire logic [3:0] O_PERIPH_CLK_EN,
  input wire logic [3:0] O_PERIPH_ACCESS_EN,
  input wire sleep_gate_pkg::analog_t O_ANALOG
);
  // one domain only
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  a_nop_cause: assert property (O_SLEEP_NOP |-> $past(I_SLEEP_INSTR))
    else $error("nop pulse without sleep request");
  a_sleep_answer: assert property (I_SLEEP_INSTR && !O_CORE_STALL |=>
    O_CORE_STALL != O_SLEEP_NOP)
    else $error("sleep request not answered once");
  a_cpu_stopped: assert property ($rose(O_CORE_STALL) |=>
    !O_CLK_DOM.cpu && !O_CLK_DOM.flash)
    else $error("cpu clock runs in sleep");
  a_gate_access: assert property (!O_CORE_STALL |->
    O_PERIPH_ACCESS_EN == O_PERIPH_CLK_EN)
    else $error("access and clock gate disagree");
  a_gate_sleep: assert property (!O_CLK_DOM.io |->
    O_PERIPH_CLK_EN == 4'h0)
    else $error("peripheral clock runs with io clock off");
  a_bod_kept: assert property (I_BOD_FUSE_EN [*6] |-> O_ANALOG.bod_on)
    else $error("brown-out detector dropped");
  a_wdt_kept: assert property (I_WDT_EN [*6] |-> O_ANALOG.wdt_run)
    else $error("watchdog stopped");
  a_ref_need: assert property (O_ANALOG.bod_on || O_ANALOG.adc_on |->
    O_ANALOG.ref_on)
    else $error("reference off while needed");
  a_comp_deep: assert property (O_CORE_STALL &&
    !O_ANALOG.in_buf_on |-> !O_ANALOG.comp_on)
    else $error("comparator on in deep sleep");
  a_wake_halt: assert property ($rose(I_WAKE_IRQ) && O_CORE_STALL |->
    O_CORE_STALL [*6] ##[1:40] !O_CORE_STALL)
    else $error("wake sequence length wrong");
  a_gate_reserved: assert property (O_PREADY && !I_PWRITE &&
    I_PADDR == sleep_gate_pkg::OFS_GATING |-> O_PRDATA[31:4] == 28'h0)
    else $error("gating reserved bits nonzero");
  a_ctrl_reserved: assert property (O_PREADY && !I_PWRITE &&
    I_PADDR == sleep_gate_pkg::OFS_CORE_CONTROL |->
    O_PRDATA[31:8] == 24'h0 && !O_PRDATA[2])
    else $error("control reserved bit nonzero");
endmodule : sleep_gate_sva
bind sleep_gate sleep_gate_sva i_sva (.*);
`default_nettype wire

// *** dv/sleep_gate_test.sv ***
/*
  self-checking bench for the sleep and peripheral gating block.
  assumes the package is compiled first; apb reads queue their expected answer.
*/
`timescale 1ns/1ps
`default_nettype none
module sleep_gate_test;
  // bus and core stimulus
  logic clock, reset_n, psel, penable, pwrite, sinstr, wake;
  logic xtal, bod, wdt, adc, comp, cref;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic pready, pslverr, stall, nop;
  logic [3:0] clk_en, acc_en;
  sleep_gate_pkg::clk_dom_t dom;
  sleep_gate_pkg::analog_t ana;
  logic [32:0] expq[$];
  int n_fail, n_tests, cyc, seed, n, md, em;
  localparam logic [7:0] gat_a = sleep_gate_pkg::OFS_GATING;
  localparam logic [7:0] ctl_a = sleep_gate_pkg::OFS_CORE_CONTROL;
  localparam int STARTUP = 2; // short start-up for the bench
  sleep_gate #(.STARTUP_CYCLES(STARTUP)) i_dut (
    .I_CLOCK(clock), .I_RESET_N(reset_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_PRDATA(prdata), .I_SLEEP_INSTR(sinstr), .O_CORE_STALL(stall),
    .O_SLEEP_NOP(nop), .I_WAKE_IRQ(wake), .I_CRYSTAL_SEL(xtal),
    .I_BOD_FUSE_EN(bod), .I_WDT_EN(wdt), .I_ADC_EN(adc),
    .I_COMP_EN(comp), .I_COMP_USES_REF(cref), .O_CLK_DOM(dom),
    .O_PERIPH_CLK_EN(clk_en), .O_PERIPH_ACCESS_EN(acc_en), .O_ANALOG(ana)
  );
  // 100 MHz clock
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic close_out;
    // a read note never answered counts as a miss
    if (expq.size() != 0)
      n_fail++;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // one apb transfer; a read notes its expected {error, data}
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [32:0] e);
    if (!w)
      expq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // hold the request until ready; only the hang guard ends this
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : apb
  // one-cycle sleep request, returns once the answer is settled
  task automatic pulse;
    sinstr <= 1'b1;
    @(posedge clock);
    sinstr <= 1'b0;
    @(posedge clock);
  endtask : pulse
  // read answers against the oldest note
  always @(posedge clock)
    if (pready === 1'b1 && psel && penable && !pwrite && expq.size() > 0)
      chk({pslverr, prdata}, expq.pop_front());
  // hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      close_out;
    end
  end
  initial
  begin
    {reset_n, psel, penable, pwrite, sinstr, wake} = 6'h0;
    {xtal, bod, wdt, adc, comp, cref} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    seed = 44;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    // all clocks and access on, reference off, converter cold
    chk(33'({clk_en, acc_en, ana}), 33'hFF51);
    apb(0, gat_a, 32'h0, 33'h0);
    apb(1, gat_a, 32'hFFFFFFFF, 33'h0);
    apb(0, gat_a, 32'h0, 33'hF);
    // each gate bit alone with its peripheral idle, then released
    for (int k = 0; k < 4; k++)
    begin
      apb(1, gat_a, 32'h1 << k, 33'h0);
      rnd = 32'({2{~(4'h1 << k)}});
      chk(33'({clk_en, acc_en}), 33'(rnd[7:0]));
      apb(1, gat_a, 32'h0, 33'h0);
      chk(33'({clk_en, acc_en}), 33'hFF);
    end
    repeat (4)
    begin
      rnd = $random(seed);
      apb(1, ctl_a, rnd, 33'h0);
      apb(0, ctl_a, 32'h0, {25'h0, rnd[7:0] & 8'hF8});
    end
    // unmapped place refuses and leaves gating alone
    apb(1, 8'h0C, 32'hFF, 33'h0);
    apb(0, 8'h0C, 32'h0, {1'b1, 32'h0});
    apb(0, gat_a, 32'h0, 33'h0);
    // unarmed sleep is a no-operation
    apb(1, ctl_a, 32'h10, 33'h0);
    pulse;
    chk(33'({nop, stall}), 33'h2);
    {xtal, bod, wdt, adc, comp} <= 5'h1F;
    repeat (8) @(posedge clock);
    // converter up: plain conversions, mux free
    chk(33'({ana.adc_extended, ana.comp_adc_mux}), 33'h1);
    // every sleep mode armed then woken; last pass is standby, no crystal
    for (int m = 0; m < 5; m++)
    begin
      md = (m == 4) ? 3 : m;
      em = (m == 4) ? 2 : m;
      if (m == 4)
        xtal <= 1'b0;
      apb(1, ctl_a, 32'h20 | (md << 3), 33'h0);
      pulse;
      repeat (5) @(posedge clock);
      // stall, clocks {cpu,flash,io,adc,osc}, analog levels
      rnd = 32'({1'b1, 2'h0, em == 0, em < 2, em != 2, 2'h2, em < 2,
        4'hF, em < 2});
      chk(33'({stall, dom, ana}), 33'(rnd[13:0]));
      wake <= 1'b1;
      n = 0;
      while (stall !== 1'b0 && n < 200)
      begin
        @(posedge clock);
        n++;
      end
      wake <= 1'b0;
      // two sync edges, entry, start-up, four halt cycles, the drop
      md = 4 + sleep_gate_pkg::WAKE_HALT_CYCLES;
      md += (em == 3) ? sleep_gate_pkg::STANDBY_WAKE_CYCLES : STARTUP;
      chk(33'(n), 33'(md));
      apb(1, ctl_a, 32'h0, 33'h0);
    end
    // converter off first, then gated: next conversion extended
    adc <= 1'b0;
    repeat (6) @(posedge clock);
    apb(1, gat_a, 32'h1, 33'h0);
    chk(33'({ana.adc_on, ana.adc_extended}), 33'h1);
    chk(33'(ana.comp_adc_mux), 33'h0);
    apb(1, gat_a, 32'h0, 33'h0);
    close_out;
  end
endmodule : sleep_gate_test
`default_nettype wire
